// *** rsc_map.vh ***
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_ADDR_W           4
`define RSC_OFF_STATUS       4'h0
`define RSC_OFF_EVENT        4'h4
`define RSC_BIT_POR          0
`define RSC_BIT_BOR          1
`define RSC_BIT_IDLE         2
`define RSC_BIT_SLEEP        3
`define RSC_BIT_WATCHDOG_TIMEOUT_FLAG         4
`define RSC_BIT_WDT_EN       5
`define RSC_BIT_SWR          6
`define RSC_BIT_PIN          7
`define RSC_BIT_REG          8
`define RSC_BIT_IOP          14
`define RSC_BIT_TRAP         15
`define RSC_IMPL_MASK        16'hC1FF
`define RSC_POR_VALUE        16'h0001
`define RSC_RESP_OKAY        2'h0
`define RSC_RESP_SLVERR      2'h2
`endif

// *** rsc_sync.v ***
`timescale 1ns/1ns
// three-stage synchroniser; output changes once stages two and three agree
module rsc_sync (
  aclk,
  aresetn,
  din,
  dout
);
  input  wire aclk;
  input  wire aresetn;
  input  wire din;
  output reg  dout;

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      // rest at the idle high level so release gives no false edge
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      dout   <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // rsc_sync

// *** rsc_reset_combiner.v ***
// Notes on behaviour
// RULE1 - master reset active whenever any reset source is active
// RULE2 - every reset kind sets its own cause flag
// RULE3 - power-on clears all flags except bit 0, which it sets
// RULE4 - software may set or clear any implemented bit anytime; a hardware set in the same cycle wins over a software clear
// RULE5 - software-set cause flags never cause a real reset
// RULE6 - software should clear flags after reading them
// RULE7 - bit 15 set by trap conflict reset
// RULE8 - bit 14 set by illegal opcode or uninitialised W reset
// RULE9 - bit 8 one keeps regulator active in sleep
// RULE10 - bit 7 set by master-clear pin reset
// RULE11 - bit 6 set by reset instruction
// RULE12 - bit 5 software watchdog enable
// RULE13 - fuse at one forces watchdog enabled
// RULE14 - bit 4 set on watchdog time-out
// RULE15 - bit 3 set once device has been in sleep
// RULE16 - bit 2 set once device has been in idle
// RULE17 - bit 1 set by brown-out reset
// RULE18 - bit 0 set by power-up reset
// RULE19 - bits 13 to 9 read zero, writes ignored
// RULE20 - non-power-on resets set only their own flag
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_reset_combiner (
  aclk,
  aresetn,
  power_on_reset,
  brownout_reset,
  master_clear_pin_n,
  reset_instruction,
  watchdog_timeout,
  trap_conflict,
  illegal_op,
  sleep_entry,
  idle_entry,
  watchdog_fuse_enable,
  system_master_reset,
  watchdog_enable,
  regulator_sleep_active,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  input  wire                   aclk;
  input  wire                   aresetn;
  input  wire                   power_on_reset;
  input  wire                   brownout_reset;
  input  wire                   master_clear_pin_n;
  input  wire                   reset_instruction;
  input  wire                   watchdog_timeout;
  input  wire                   trap_conflict;
  input  wire                   illegal_op;
  input  wire                   sleep_entry;
  input  wire                   idle_entry;
  input  wire                   watchdog_fuse_enable;
  output wire                   system_master_reset;
  output reg                    watchdog_enable;
  output reg                    regulator_sleep_active;
  input  wire [`RSC_ADDR_W-1:0] s_axi_awaddr;
  input  wire                   s_axi_awvalid;
  output wire                   s_axi_awready;
  input  wire [31:0]            s_axi_wdata;
  input  wire [3:0]             s_axi_wstrb;
  input  wire                   s_axi_wvalid;
  output wire                   s_axi_wready;
  output reg  [1:0]             s_axi_bresp;
  output reg                    s_axi_bvalid;
  input  wire                   s_axi_bready;
  input  wire [`RSC_ADDR_W-1:0] s_axi_araddr;
  input  wire                   s_axi_arvalid;
  output wire                   s_axi_arready;
  output reg  [31:0]            s_axi_rdata;
  output reg  [1:0]             s_axi_rresp;
  output reg                    s_axi_rvalid;
  input  wire                   s_axi_rready;

  // power-on comes from the analogue domain and acts asynchronously on
  // the combined reset; other sources are on-clock except the pin
  wire pin_active;
  wire pin_sync_n;

  rsc_sync u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (master_clear_pin_n),
    .dout    (pin_sync_n)
  );

  reg pin_seen_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_seen_reg <= 1'b0;
    end else begin
      pin_seen_reg <= 1'b1;
    end
  end
  // synchroniser rests high in reset, so no pin event follows release
  assign pin_active = pin_seen_reg & ~pin_sync_n;

  wire [6:0] src_vec;
  assign src_vec = {trap_conflict, illegal_op, pin_active, reset_instruction,
                    watchdog_timeout, brownout_reset, power_on_reset};
  assign system_master_reset = |src_vec; // [RULE1] [RULE5]

  // write channel capture
  reg                   aw_full_reg;
  reg [`RSC_ADDR_W-1:0] aw_addr_reg;
  reg                   w_full_reg;
  reg [31:0]            w_data_reg;
  reg [3:0]             w_strb_reg;

  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_go;
  assign wr_go = aw_full_reg & w_full_reg;

  wire wr_status;
  assign wr_status = wr_go && (aw_addr_reg[`RSC_ADDR_W-1:2] ==
                               `RSC_OFF_STATUS >> 2);
  wire wr_mapped;
  assign wr_mapped = (aw_addr_reg[`RSC_ADDR_W-1:2] == `RSC_OFF_STATUS >> 2) ||
                     (aw_addr_reg[`RSC_ADDR_W-1:2] == `RSC_OFF_EVENT >> 2);

  reg [15:0] status_reg;
  reg [15:0] status_next;
  reg [15:0] wmask;
  reg [15:0] hw_set;

  always @* begin
    wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}} & `RSC_IMPL_MASK;
    hw_set = 16'h0000;
    hw_set[`RSC_BIT_TRAP]  = trap_conflict;      // [RULE2] [RULE7]
    hw_set[`RSC_BIT_IOP]   = illegal_op;         // [RULE8]
    hw_set[`RSC_BIT_PIN]   = pin_active;         // [RULE10]
    hw_set[`RSC_BIT_SWR]   = reset_instruction;  // [RULE11]
    hw_set[`RSC_BIT_WATCHDOG_TIMEOUT_FLAG]  = watchdog_timeout;   // [RULE14]
    hw_set[`RSC_BIT_SLEEP] = sleep_entry;        // [RULE15]
    hw_set[`RSC_BIT_IDLE]  = idle_entry;         // [RULE16]
    hw_set[`RSC_BIT_BOR]   = brownout_reset;     // [RULE17]
    status_next = status_reg;
    if (wr_status) begin
      status_next = (status_reg & ~wmask) | (w_data_reg[15:0] & wmask); // [RULE4]
    end
    // hardware set wins over a software clear in the same cycle
    status_next = (status_next | hw_set) & `RSC_IMPL_MASK; // [RULE19] [RULE20]
  end

  always @(posedge aclk or posedge power_on_reset) begin
    if (power_on_reset) begin
      status_reg <= `RSC_POR_VALUE; // [RULE3] [RULE18]
    end else if (!aresetn) begin
      status_reg <= status_reg;
    end else begin
      status_reg <= status_next;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_enable        <= 1'b1;
      regulator_sleep_active <= 1'b0;
    end else begin
      watchdog_enable <= watchdog_fuse_enable | status_reg[`RSC_BIT_WDT_EN]; // [RULE12] [RULE13]
      regulator_sleep_active <= status_reg[`RSC_BIT_REG]; // [RULE9]
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= {`RSC_ADDR_W{1'b0}};
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // event register reads the live source levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RSC_RESP_OKAY;
      if (s_axi_araddr[`RSC_ADDR_W-1:2] == `RSC_OFF_STATUS >> 2) begin
        s_axi_rdata <= {16'h0000, status_reg};
      end else if (s_axi_araddr[`RSC_ADDR_W-1:2] == `RSC_OFF_EVENT >> 2) begin
        s_axi_rdata <= {24'h000000, watchdog_enable, src_vec};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RSC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // rsc_reset_combiner

// *** rsc_monitor.sv ***
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_monitor (
  input wire aclk, aresetn, power_on_reset, brownout_reset, master_clear_pin_n,
  input wire reset_instruction, watchdog_timeout, trap_conflict, illegal_op,
  input wire watchdog_fuse_enable, system_master_reset, watchdog_enable,
  input wire regulator_sleep_active, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire [3:0] s_axi_awaddr, s_axi_wstrb,
  input wire [31:0] s_axi_wdata, s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire src = power_on_reset | brownout_reset | reset_instruction | watchdog_timeout
             | trap_conflict | illegal_op;
  wire wr0 = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready
             & (s_axi_awaddr == `RSC_OFF_STATUS) & !power_on_reset;
  wire ar = s_axi_arvalid & s_axi_arready;
  a_src_or: assert property (src |-> system_master_reset)
    else $error("source without master reset");
  a_soft_quiet: assert property ((!src && master_clear_pin_n) [*6] |-> !system_master_reset)
    else $error("master reset with no source");
  a_fuse_wdt: assert property ($past(watchdog_fuse_enable) |-> watchdog_enable)
    else $error("fuse did not force watchdog");
  a_soft_wdt: assert property (wr0 && s_axi_wstrb[0] |-> ##3 watchdog_enable ==
    ($past(s_axi_wdata[5], 3) | $past(watchdog_fuse_enable))) else $error("watchdog enable wrong");
  a_reg_sleep: assert property (wr0 && s_axi_wstrb[1] |->
    ##3 regulator_sleep_active == $past(s_axi_wdata[8], 3)) else $error("regulator bit wrong");
  a_write_resp: assert property (wr0 |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (ar |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_rd_mask: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF3E00) == 32'h0)
    else $error("unimplemented bits read nonzero");
  cover property (wr0);
  cover property (ar);
  cover property (system_master_reset && !power_on_reset);
endmodule // rsc_monitor
bind rsc_reset_combiner rsc_monitor rsc_monitor_i (.*);

// *** rsc_src_model.sv ***
`timescale 1ns/1ns
module rsc_src_model (
  input  wire       aclk,
  input  wire       go,
  input  wire [2:0] kind,
  output reg  [6:0] src = 7'h00
);
  // one-cycle event on the selected source line
  always @(posedge aclk) begin
    src <= go ? 7'h01 << kind : 7'h00;
  end
endmodule // rsc_src_model

// *** rsc_reset_combiner_tb.sv ***
`timescale 1ns/1ns
module rsc_reset_combiner_tb;
  reg aclk = 0, aresetn = 0, power_on_reset = 1, master_clear_pin_n = 1;
  reg watchdog_fuse_enable = 0, go = 0, ra, rw, rd;
  reg [2:0] kind = 3'h0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h0, rv;
  reg [1:0] rp;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire brownout_reset, reset_instruction, watchdog_timeout, trap_conflict, illegal_op;
  wire sleep_entry, idle_entry, system_master_reset, watchdog_enable, regulator_sleep_active;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_fail = 0, checks = 0, k;
  reg [15:0] ev;
  // flag position of each modelled source, index 0 in the lowest nibble
  localparam [27:0] POS = {4'h2, 4'h3, 4'hE, 4'hF, 4'h4, 4'h6, 4'h1};
  always #4 aclk = ~aclk;
  rsc_reset_combiner rsc_reset_combiner_i (.*);
  rsc_src_model rsc_src_model_i (.aclk(aclk), .go(go), .kind(kind), .src({idle_entry,
    sleep_entry, illegal_op, trap_conflict, watchdog_timeout, reset_instruction, brownout_reset}));
  task chk(input [31:0] got, input [31:0] exp, input [47:0] what);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do begin
        @(negedge aclk);
        ra = w ? s_axi_awready : s_axi_arready;
        rw = s_axi_wready;
        rd = w ? s_axi_bvalid : s_axi_rvalid;
        rv = s_axi_rdata;
        rp = w ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
        if (ra) s_axi_awvalid <= 0;
        if (ra) s_axi_arvalid <= 0;
        if (rw) s_axi_wvalid <= 0;
      end while (!rd);
      s_axi_bready <= 0;
      s_axi_rready <= 0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    power_on_reset <= 0;
    bus(0, 4'h0, 0);
    chk(rv, 32'h1, "por");
    bus(1, 4'h0, 32'hFFFF);
    bus(0, 4'h0, 0);
    chk(rv, 32'hC1FF, "all");
    chk(regulator_sleep_active, 1, "reg");
    chk(watchdog_enable, 1, "wdt");
    bus(1, 4'h0, 0);
    bus(0, 4'h0, 0);
    chk(rv, 0, "clr");
    chk(regulator_sleep_active, 0, "reg");
    chk(watchdog_enable, 0, "wdt");
    @(posedge aclk) watchdog_fuse_enable <= 1;
    repeat (3) @(negedge aclk);
    chk(watchdog_enable, 1, "fuse");
    bus(0, 4'h4, 0);
    chk(rv, 32'h80, "event");
    chk(rp, 0, "rresp");
    @(posedge aclk) watchdog_fuse_enable <= 0;
    ev = 16'h0;
    for (k = 0; k < 7; k = k + 1) begin
      @(posedge aclk) kind <= k;
      go <= 1;
      @(posedge aclk) go <= 0;
      @(negedge aclk);
      chk(system_master_reset, k < 5, "rst");
      ev = ev | (16'h1 << POS[k*4 +: 4]);
      bus(0, 4'h0, 0);
      chk(rv, ev, "flag");
    end
    @(posedge aclk) master_clear_pin_n <= 0;
    repeat (6) @(negedge aclk);
    chk(system_master_reset, 1, "pin");
    @(posedge aclk) master_clear_pin_n <= 1;
    repeat (6) @(posedge aclk);
    bus(0, 4'h0, 0);
    chk(rv, ev | 16'h80, "pin");
    bus(1, 4'h0, 32'hC1DE);
    chk(rp, 0, "bresp");
    repeat (3) @(negedge aclk);
    chk(system_master_reset, 0, "soft");
    bus(0, 4'h8, 0);
    chk(rv, 0, "unmap");
    chk(rp, 2, "unresp");
    bus(1, 4'h8, 32'hFFFF);
    chk(rp, 2, "unwr");
    @(posedge aclk) power_on_reset <= 1;
    @(posedge aclk) power_on_reset <= 0;
    bus(0, 4'h0, 0);
    chk(rv, 32'h1, "por2");
    tally_and_finish;
  end
endmodule // rsc_reset_combiner_tb
